// file: include/wdog_pkg.sv
package wdog_pkg;

    // Register map, byte addresses on the APB bus.
    localparam int unsigned ADDR_W        = 8;
    localparam logic [7:0]  CAUSE_OFF     = 8'h00;
    localparam logic [7:0]  CTRL_OFF      = 8'h04;

    // Reset values of the two registers.
    localparam logic [7:0]  CAUSE_POR_VAL = 8'h01;
    localparam logic [7:0]  CTRL_RST_VAL  = 8'h00;

    // Timing: oscillator rate, base period and the change window.
    localparam logic [31:0] OSC_FREQ_HZ   = 32'h0001_F400;
    localparam logic [31:0] CLK_FREQ_HZ   = 32'h05F5_E100;
    localparam int unsigned CNT_W         = 21;
    localparam logic [20:0] PERIOD_BASE   = 21'h00_0800;
    localparam logic [3:0]  PERIOD_MAX    = 4'h9;
    localparam logic [2:0]  CE_CYCLES     = 3'h4;

    typedef enum logic [1:0] {
        MODE_STOPPED    = 2'b00,
        MODE_IRQ_ONLY   = 2'b01,
        MODE_RESET_ONLY = 2'b10,
        MODE_IRQ_RESET  = 2'b11
    } wdog_mode_t;

    // Field layout of the control and status byte.
    typedef struct packed {
        logic       irq_flag;
        logic       irq_enable;
        logic       period_hi;
        logic       change_enable;
        logic       reset_enable;
        logic [2:0] period_lo;
    } wdog_ctrl_t;

    // Field layout of the reset cause byte.
    typedef struct packed {
        logic [3:0] reserved;
        logic       wdog_reset_flag;
        logic       brownout_reset_flag;
        logic       pin_reset_flag;
        logic       poweron_reset_flag;
    } reset_cause_t;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

endpackage

// file: core/wdog_core.sv
// Contract
// RULE1: Expiry reset sends a one core clock pulse to the delay counter.
// RULE2: Counter advances on ticks of the separate 128 kHz oscillator.
// RULE3: Counter clears on restart, while disabled, and on any chip reset.
// RULE4: Reset modes: period elapsed without restart forces a system reset.
// RULE5: Fuse picks level one (starts off) or level two (always on).
// RULE6: Level one accepts setting reset enable at any time.
// RULE7: Level one disable: change+reset write, then final write in window.
// RULE8: Level two always runs and reads reset enable as one.
// RULE9: Level two period change needs change+reset write, then period write.
// RULE10: Change enable clears after four cycles; gates clears and periods.
// RULE11: Watchdog reset sets bit three; power-on or zero write clears it.
// RULE12: Brown-out reset sets bit two; power-on or zero write clears it.
// RULE13: Pin reset sets bit one; power-on or zero write clears it.
// RULE14: Power-on sets bit zero; only a zero write clears it.
// RULE15: Reset cause bits seven to four always read zero.
// RULE16: Interrupt flag set on expiry; vector taken or one write clears.
// RULE17: Interrupt request only with global enable and interrupt enable set.
// RULE18: Mode follows reset and irq enables; programmed fuse forces reset.
// RULE19: Combined mode: taking vector clears flag and interrupt enable.
// RULE20: Combined mode: unserviced interrupt at next expiry resets chip.
// RULE21: Watchdog reset flag forces reset enable to one.
// RULE22: Period code 0 to 9 selects 2048 doubling to 1048576 cycles.
// RULE23: Reserved period codes fall back to the longest valid code.
// RULE24: One writes keep cause flags; flags survive non power-on resets.
`timescale 1ns/10ps

module wdog_core #(
    parameter logic [20:0] PERIOD_BASE_CYC = wdog_pkg::PERIOD_BASE
) (
    input  wire logic              mclk_in,
    input  wire logic              rst_in,
    input  wire wdog_pkg::apb_req_t apb_req_in,
    output wdog_pkg::apb_rsp_t     apb_rsp_out,
    input  wire logic              wdog_osc_in,
    input  wire logic              safety_level_fuse_in,
    input  wire logic              wdog_restart_instr_in,
    input  wire logic              global_irq_enable_in,
    input  wire logic              irq_vector_taken_in,
    input  wire logic              brownout_reset_in,
    input  wire logic              pin_reset_in,
    output logic                   wdog_sys_rst_out,
    output logic                   wdog_irq_req_out
);
    import wdog_pkg::*;

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                      input logic [7:0] off);
        addr_hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
    endfunction

    function automatic logic [CNT_W-1:0] period_last(input logic [3:0] c);
        logic [3:0]       cc;
        logic [CNT_W-1:0] p;
        cc = (c > PERIOD_MAX) ? PERIOD_MAX : c;
        p = PERIOD_BASE_CYC << cc;
        period_last = p - 21'h00_0001;
    endfunction

    logic             fuse_s1_q;
    logic             fuse_q;
    logic             osc_s1_q;
    logic             osc_s2_q;
    logic             osc_s3_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             rst_en_q;
    logic             rst_en_d;
    logic             ie_q;
    logic             ie_d;
    logic             flag_q;
    logic             flag_d;
    logic [3:0]       per_q;
    logic [3:0]       per_d;
    logic             ce_q;
    logic             ce_d;
    logic [2:0]       ce_cnt_q;
    logic [2:0]       ce_cnt_d;
    reset_cause_t     cause_q;
    reset_cause_t     cause_d;
    logic             rst_pulse_q;
    logic             irq_q;
    logic             pready_q;
    logic             pslverr_q;
    logic [31:0]      prdata_q;

    // The fuse and oscillator pins pass two flops before any use.
    always_ff @(posedge mclk_in)
    begin
        fuse_s1_q <= safety_level_fuse_in;
        fuse_q    <= fuse_s1_q;
        osc_s1_q  <= wdog_osc_in;
        osc_s2_q  <= osc_s1_q;
        osc_s3_q  <= osc_s2_q;
    end

    wire osc_tick = osc_s2_q & ~osc_s3_q; // RULE2

    // Bus decode.
    wire setup_w   = apb_req_in.psel & ~apb_req_in.penable;
    wire hit_cause = addr_hit(apb_req_in.paddr, CAUSE_OFF);
    wire hit_ctrl  = addr_hit(apb_req_in.paddr, CTRL_OFF);
    wire wr_w      = apb_req_in.psel & apb_req_in.penable
                     & apb_req_in.pwrite & pready_q;
    wire cause_wr  = wr_w & hit_cause;
    wire ctrl_wr   = wr_w & hit_ctrl;
    wire [7:0] wbyte = apb_req_in.pwdata[7:0];
    wdog_ctrl_t wctl;
    assign wctl = wdog_ctrl_t'(wbyte);

    // Any reset other than power-on reinitialises the control register.
    wire chip_rst = rst_pulse_q | brownout_reset_in | pin_reset_in;

    wire rst_en_eff = rst_en_q | fuse_q
                      | cause_q.wdog_reset_flag; // RULE8 RULE21
    wdog_mode_t mode_w;
    assign mode_w = fuse_q ? MODE_RESET_ONLY
                           : wdog_mode_t'({rst_en_eff, ie_q}); // RULE18 RULE5
    wire running  = (mode_w != MODE_STOPPED);
    wire at_last  = (cnt_q == period_last(per_q)); // RULE22 RULE23
    wire expire   = osc_tick & running & at_last & ~chip_rst;
    wire do_reset = expire & ((mode_w == MODE_RESET_ONLY)
                    | ((mode_w == MODE_IRQ_RESET) & flag_q)); // RULE4 RULE20
    wire do_irq   = expire & ~do_reset
                    & ((mode_w == MODE_IRQ_ONLY)
                    | (mode_w == MODE_IRQ_RESET)); // RULE16
    wire irq_ack  = irq_vector_taken_in & irq_q;

    // Timed sequence: change enable plus reset enable opens the window.
    wire seq_start = ctrl_wr & wctl.change_enable & wctl.reset_enable;
    wire seq_close = ctrl_wr & ~wctl.change_enable & ce_q;

    // Counter.
    always_comb
    begin
        cnt_d = cnt_q;
        if (chip_rst | wdog_restart_instr_in | ~running | expire)
        begin
            cnt_d = '0; // RULE3
        end
        else if (osc_tick)
        begin
            cnt_d = cnt_q + 21'h00_0001; // RULE2
        end
    end

    // Control fields.
    always_comb
    begin
        rst_en_d = rst_en_q;
        ie_d     = ie_q;
        per_d    = per_q;
        ce_d     = ce_q;
        ce_cnt_d = ce_cnt_q;
        flag_d   = flag_q;
        if (ce_q)
        begin
            ce_cnt_d = ce_cnt_q - 3'h1;
            if (ce_cnt_q == 3'h1)
            begin
                ce_d = 1'b0; // RULE10
            end
        end
        if (chip_rst)
        begin
            rst_en_d = 1'b0;
            ie_d     = 1'b0;
            per_d    = 4'h0;
            ce_d     = 1'b0;
            ce_cnt_d = 3'h0;
            flag_d   = 1'b0;
        end
        else
        begin
            if (ctrl_wr)
            begin
                ie_d = wctl.irq_enable;
                if (!fuse_q)
                begin
                    // Setting is free; clearing needs the open window.
                    rst_en_d = wctl.reset_enable
                               | (rst_en_q & ~ce_q); // RULE6 RULE7 RULE10
                end
                if (wctl.irq_flag)
                begin
                    flag_d = 1'b0; // RULE16
                end
            end
            if (seq_start)
            begin
                ce_d     = 1'b1;
                ce_cnt_d = CE_CYCLES; // RULE10
            end
            else if (seq_close)
            begin
                ce_d  = 1'b0;
                per_d = {wctl.period_hi, wctl.period_lo}; // RULE9 RULE10
            end
            if (irq_ack)
            begin
                flag_d = 1'b0; // RULE16
                if (mode_w == MODE_IRQ_RESET)
                begin
                    ie_d = 1'b0; // RULE19
                end
            end
            // The hardware set beats any clear in the same cycle.
            if (do_irq)
            begin
                flag_d = 1'b1; // RULE16
            end
        end
    end

    // Cause flags: zero writes clear, one writes keep, sets win.
    always_comb
    begin
        cause_d = cause_q;
        if (cause_wr)
        begin
            cause_d = reset_cause_t'(cause_q & wbyte); // RULE24
        end
        cause_d.reserved = 4'h0; // RULE15
        if (do_reset)
        begin
            cause_d.wdog_reset_flag = 1'b1; // RULE11
        end
        if (brownout_reset_in)
        begin
            cause_d.brownout_reset_flag = 1'b1; // RULE12
        end
        if (pin_reset_in)
        begin
            cause_d.pin_reset_flag = 1'b1; // RULE13
        end
    end

    wdog_ctrl_t rctl;
    assign rctl = '{irq_flag:      flag_q,
                    irq_enable:    ie_q,
                    period_hi:     per_q[3],
                    change_enable: ce_q,
                    reset_enable:  rst_en_eff,
                    period_lo:     per_q[2:0]};
    wire [7:0] rbyte = hit_cause ? 8'(cause_q) : 8'(rctl);
    wire       rhit  = hit_cause | hit_ctrl;

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            cause_q <= reset_cause_t'(CAUSE_POR_VAL); // RULE14 RULE11
        end
        else
        begin
            cause_q <= cause_d;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            cnt_q    <= '0;
            rst_en_q <= CTRL_RST_VAL[3];
            ie_q     <= CTRL_RST_VAL[6];
            flag_q   <= CTRL_RST_VAL[7];
            per_q    <= 4'h0;
            ce_q     <= 1'b0;
            ce_cnt_q <= 3'h0;
        end
        else
        begin
            cnt_q    <= cnt_d;
            rst_en_q <= rst_en_d;
            ie_q     <= ie_d;
            flag_q   <= flag_d;
            per_q    <= per_d;
            ce_q     <= ce_d;
            ce_cnt_q <= ce_cnt_d;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            rst_pulse_q <= 1'b0;
            irq_q       <= 1'b0;
        end
        else
        begin
            rst_pulse_q <= do_reset & ~rst_pulse_q; // RULE1
            irq_q <= flag_q & ie_q & global_irq_enable_in
                     & ~fuse_q & ~irq_ack; // RULE17
        end
    end

    // Zero-wait slave: answer is ready in the first access cycle.
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end
        else
        begin
            pready_q  <= setup_w;
            pslverr_q <= setup_w & ~rhit;
            prdata_q  <= (setup_w & rhit & ~apb_req_in.pwrite)
                         ? {24'h00_0000, rbyte} : 32'h0000_0000;
        end
    end

    assign apb_rsp_out.pready  = pready_q;
    assign apb_rsp_out.pslverr = pslverr_q;
    assign apb_rsp_out.prdata  = prdata_q;
    assign wdog_sys_rst_out    = rst_pulse_q;
    assign wdog_irq_req_out    = irq_q;

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);

    a_rst_one_cycle: assert property ( // RULE1
        wdog_sys_rst_out |=> !wdog_sys_rst_out)
        else $error("watchdog reset pulse longer than one cycle");
    a_rst_sets_flag: assert property ( // RULE11
        wdog_sys_rst_out |-> cause_q.wdog_reset_flag)
        else $error("watchdog reset without cause flag");
    a_rst_clears_cnt: assert property ( // RULE3
        wdog_sys_rst_out |=> (cnt_q == '0) && !ie_q)
        else $error("chip reset did not clear counter");
    a_restart_clears: assert property ( // RULE3
        wdog_restart_instr_in |=> (cnt_q == '0))
        else $error("restart did not clear counter");
    a_level2_wde: assert property ( // RULE8
        fuse_q |-> rctl.reset_enable && !wdog_irq_req_out)
        else $error("level two reset enable not read as one");
    a_wdog_reset_flag_forces: assert property ( // RULE21
        cause_q.wdog_reset_flag |-> rctl.reset_enable)
        else $error("reset enable clear while reset flag set");
    // A closing write may end the window early; it must never outlive
    // four cycles unless software reopens it.
    a_ce_window: assert property ( // RULE10
        $rose(ce_q) && !seq_start ##1 (!seq_start) [*3] |-> ##1 !ce_q)
        else $error("change enable window longer than four cycles");
    a_ce_early_close: assert property ( // RULE10
        ce_q && !seq_close && !chip_rst && (ce_cnt_q != 3'h1) |=> ce_q)
        else $error("change enable window closed early");
    a_period_lock: assert property ( // RULE10
        $changed(per_q) && !$past(chip_rst) |-> $past(ce_q))
        else $error("period changed outside window");
    a_irq_gate: assert property ( // RULE17
        wdog_irq_req_out |-> $past(flag_q) && $past(ie_q)
                             && $past(global_irq_enable_in))
        else $error("interrupt request without enables");
    a_cause_rsvd: assert property ( // RULE15
        cause_q.reserved == 4'h0)
        else $error("reserved cause bits not zero");
    a_por_flag: assert property ( // RULE14
        $past(rst_in) |-> cause_q.poweron_reset_flag)
        else $error("power-on flag not set");

    c_reset_fired: cover property (wdog_sys_rst_out);
    c_irq_fired:   cover property (wdog_irq_req_out ##1 irq_vector_taken_in);
    c_seq_close:   cover property (ce_q ##[1:3] seq_close);
    c_irq_then_rst: cover property (
        (mode_w == MODE_IRQ_RESET) && do_irq ##[1:1000] do_reset);

endmodule // wdog_core

// file: tb/testbench.sv
`timescale 1ns/10ps

module testbench;
    import wdog_pkg::*;

    // Short base count and a fast oscillator keep the run brief; the
    // block only counts oscillator edges, so the scaling is exact.
    localparam logic [20:0] BASE    = 21'h00_0004;
    localparam int          TICK_NS = 206;

    logic        mclk_in;
    logic        rst_in;
    apb_req_t    req;
    apb_rsp_t    rsp;
    logic        osc;
    logic        fuse;
    logic        kick_q;
    logic        gie;
    logic        vec;
    logic        bod;
    logic        pin;
    logic        sys_rst;
    logic        irq;
    int          miscompares;
    int          checks_done;
    int          rst_cnt;
    int          t;
    logic [40:0] exp_q[$];
    logic [40:0] ent;

    wdog_core #(
        .PERIOD_BASE_CYC(BASE)
    ) DUT (
        .mclk_in              (mclk_in),
        .rst_in               (rst_in),
        .apb_req_in           (req),
        .apb_rsp_out          (rsp),
        .wdog_osc_in          (osc),
        .safety_level_fuse_in (fuse),
        .wdog_restart_instr_in(kick_q),
        .global_irq_enable_in (gie),
        .irq_vector_taken_in  (vec),
        .brownout_reset_in    (bod),
        .pin_reset_in         (pin),
        .wdog_sys_rst_out     (sys_rst),
        .wdog_irq_req_out     (irq)
    );

    initial
    begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end

    initial
    begin
        osc = 1'b0;
        forever #(TICK_NS / 2) osc = ~osc;
    end

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Read data and error are checked by the monitor below, in order.
    always @(posedge mclk_in)
    begin
        if (req.psel && req.penable && rsp.pready === 1'b1)
        begin
            ent = exp_q.pop_front();
            if (ent[40])
                chk({rsp.pslverr, rsp.prdata}, ent[32:0]);
            else
                chk({rsp.pslverr, 32'h0000_0000}, {ent[32], 32'h0000_0000});
        end
        if (sys_rst === 1'b1)
            rst_cnt++;
    end

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [7:0] d, input logic err);
        int n;
        n = 0;
        exp_q.push_back({!wr, 7'h00, err, 24'h00_0000, err ? 8'h00 : d});
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite  <= wr;
        req.paddr   <= a;
        req.pwdata  <= {24'($urandom()), d};
        @(posedge mclk_in);
        req.penable <= 1'b1;
        @(posedge mclk_in);
        while (rsp.pready !== 1'b1 && n < 20)
        begin
            @(posedge mclk_in);
            n++;
        end
        if (n == 20)
            chk(33'h0_0000_0000, 33'h1_0000_0000);
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
        @(posedge mclk_in);
    endtask

    task automatic wc(input logic [7:0] d);
        apb(1'b1, CTRL_OFF, d, 1'b0);
    endtask

    task automatic rc(input logic [7:0] d);
        apb(1'b0, CTRL_OFF, d, 1'b0);
    endtask

    task automatic wa(input logic [7:0] d);
        apb(1'b1, CAUSE_OFF, d, 1'b0);
    endtask

    task automatic ra(input logic [7:0] d);
        apb(1'b0, CAUSE_OFF, d, 1'b0);
    endtask

    task automatic kick;
        kick_q <= 1'b1;
        @(posedge mclk_in);
        kick_q <= 1'b0;
    endtask

    task automatic wrst(input int lo, input int hi);
        int n;
        n = 0;
        while (sys_rst !== 1'b1 && n < hi)
        begin
            @(posedge mclk_in);
            n++;
        end
        chk(33'(n >= lo && n < hi), 33'h1);
        @(posedge mclk_in);
        chk(33'(sys_rst), 33'h0);
    endtask

    // Clearing the flag byte first lets reset enable be dropped.
    task automatic disarm;
        wa(8'h00);
        wc(8'h18);
        wc(8'h80);
    endtask

    initial
    begin
        rst_in = 1'b1;
        req = '0;
        fuse = 1'b0;
        kick_q = 1'b0;
        gie = 1'b0;
        vec = 1'b0;
        bod = 1'b0;
        pin = 1'b0;
        miscompares = 0;
        checks_done = 0;
        rst_cnt = 0;
        void'($urandom(32'h78d4));
        repeat (3) @(posedge mclk_in);
        rst_in <= 1'b0;
        @(posedge mclk_in);
        ra(CAUSE_POR_VAL);
        rc(CTRL_RST_VAL);
        wa(8'hFF);
        ra(8'h01);
        apb(1'b1, 8'h08, 8'h00, 1'b1);
        apb(1'b0, 8'h08, 8'h00, 1'b1);
        wa(8'h00);
        ra(8'h00);
        wc(8'h09);
        rc(8'h08);
        wc(8'h18);
        wc(8'h01);
        rc(8'h01);
        wc(8'h09);
        kick();
        wc(8'h18);
        repeat (8) @(posedge mclk_in);
        rc(8'h09);
        wc(8'h00);
        rc(8'h09);
        kick();
        wrst(140, 199);
        ra(8'h08);
        wc(8'h18);
        wc(8'h00);
        rc(8'h08);
        disarm();
        rc(8'h00);
        $display("test registers done");
        for (int c = 0; c < 16; c += 15)
        begin
            t = 4 << (c > 9 ? 9 : c);
            wc(8'h18);
            wc({2'b00, 1'(c >> 3), 2'b01, 3'(c)});
            kick();
            wrst((t - 1) * 20, (t + 1) * 21 + 10);
            disarm();
        end
        wc(8'h08);
        t = rst_cnt;
        repeat (5)
        begin
            repeat (50) @(posedge mclk_in);
            kick();
        end
        chk(33'(rst_cnt), 33'(t));
        disarm();
        $display("test period done");
        wc(8'h40);
        kick();
        repeat (100) @(posedge mclk_in);
        rc(8'hC0);
        chk(33'(irq), 33'h0);
        gie <= 1'b1;
        repeat (3) @(posedge mclk_in);
        chk(33'(irq), 33'h1);
        wc(8'hC0);
        rc(8'h40);
        disarm();
        wc(8'h48);
        kick();
        t = rst_cnt;
        repeat (100) @(posedge mclk_in);
        rc(8'hC8);
        chk(33'(rst_cnt), 33'(t));
        vec <= 1'b1;
        @(posedge mclk_in);
        vec <= 1'b0;
        rc(8'h08);
        wrst(0, 200);
        disarm();
        wc(8'h48);
        kick();
        wrst(140, 199);
        disarm();
        $display("test interrupt done");
        bod <= 1'b1;
        @(posedge mclk_in);
        bod <= 1'b0;
        repeat (3) @(posedge mclk_in);
        ra(8'h04);
        pin <= 1'b1;
        @(posedge mclk_in);
        pin <= 1'b0;
        repeat (3) @(posedge mclk_in);
        ra(8'h06);
        rst_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        rst_in <= 1'b0;
        @(posedge mclk_in);
        ra(8'h01);
        $display("test cause done");
        fuse <= 1'b1;
        rst_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge mclk_in);
        kick();
        rc(8'h08);
        wc(8'h00);
        rc(8'h08);
        wc(8'h18);
        wc(8'h01);
        rc(8'h09);
        kick();
        wrst(140, 199);
        $display("test level two done");
        print_verdict();
    end

    initial
    begin
        // The longest period test needs about 42000 cycles; the rest is short.
        repeat (90000) @(posedge mclk_in);
        miscompares++;
        print_verdict();
    end

endmodule // testbench
